/* File: hw/pled_stretch.v */
/*
  Event pulse stretcher counting whole milliseconds.
  Assumes a one-cycle ms_tick enable from the parent's divider.
*/
`timescale 1ns/100ps
module pled_stretch (
  input  wire       clk,
  input  wire       rst,
  input  wire       ev,
  input  wire       ms_tick,
  input  wire [6:0] dur_ms,
  output wire       active
);
  reg [6:0] cnt_r;

  // load one extra tick: the first tick may come at once, so the hold is
  // never shorter than the duration; a new event restarts the interval
  always @(posedge clk or posedge rst) begin
    if (rst)
      cnt_r <= 7'h00;
    else if (ev)
      cnt_r <= dur_ms + 7'h01;
    else if (ms_tick && (cnt_r != 7'h00))
      cnt_r <= cnt_r - 7'h01;
  end

  assign active = ev | (cnt_r != 7'h00);
endmodule // pled_stretch

/* File: hw/pled_sync.v */
/*
  Three-flop synchroniser for one status input from outside the clock
  domain. Assumes a single system clock and an async active-high reset.
*/
`timescale 1ns/100ps
module pled_sync (
  input  wire clk,
  input  wire rst,
  input  wire d,
  output reg  q
);
  reg f1_r;
  reg f2_r;
  reg f3_r;

  // first flop feeds only the second; output moves when 2nd and 3rd agree
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      f1_r <= 1'b0;
      f2_r <= 1'b0;
      f3_r <= 1'b0;
      q    <= 1'b0;
    end else begin
      f1_r <= d;
      f2_r <= f1_r;
      f3_r <= f2_r;
      if (f2_r == f3_r)
        q <= f3_r;
    end
  end
endmodule // pled_sync

/* File: hw/pled_top.v */
/*
  Per-port indicator control: configuration register, event stretching,
  test blink patterns and the three indicator outputs, discrete and serial.
  Assumes the management interface decodes frames and presents a register
  address with one-cycle read and write strobes on CLOCK; status inputs
  come from port logic that may run on other clocks.
*/
`timescale 1ns/100ps
`include "pled_regs.vh"

// Function
// - Indicator one select at bits 15:12, reset shows port speed continuously.
// - Codes 0001, 0010, 0011 show transmit, receive, collision, stretched.
// - Code 0100 shows link, 0101 duplex, both continuous and unstretched.
// - Code 0111 shows stretched receive-or-transmit activity.
// - Codes 1000 on, 1001 off, 1010 fast blink, 1011 slow blink.
// - 1100 link plus receive, 1110 link plus activity; 0110, 1111 reserved.
// - Combined link displays stay solidly on while link is up.
// - Secondary event in combined link displays makes the indicator blink.
// - Duplex combined display solid while full duplex, blinks on collision.
// - Combined displays always stretch, regardless of the global enable.
// - Duplex indication may linger briefly after link loss.
// - Indicator two select at bits 11:8, same codes, resets to link.
// - Indicator three select at bits 7:4, same codes, resets to receive.
// - Bits 3:2 pick stretch 30, 60 or 100 ms; 11 reserved; reset 00.
// - Bit 1 enables stretching of the transmit, receive, collision and activity codes; resets to one.
// - Bit 0 sets serial polarity: one active high, zero active low.
module pled_top #(
  parameter MS_TICK_CYC = `PLED_MS_TICK_CYC
) (
  input  wire        CLOCK,
  input  wire        SYS_RST,
  input  wire [4:0]  REG_ADDR,
  input  wire        REG_WR,
  input  wire        REG_RD,
  input  wire [15:0] REG_WDATA,
  output reg  [15:0] REG_RDATA,
  output reg         REG_RVALID,
  input  wire        LINK_UP,
  input  wire        SPEED_100,
  input  wire        FULL_DUPLEX,
  input  wire        TX_ACT,
  input  wire        RX_ACT,
  input  wire        COLLISION,
  output reg  [2:0]  IND_ON,
  output reg  [2:0]  IND_SER
);

  // event part of a select code; zero for continuous and reserved codes
  function ev_of;
    input [3:0] sel;
    input       tx;
    input       rx;
    input       col;
    begin
      case (sel)
        `PLED_SEL_TX:       ev_of = tx;
        `PLED_SEL_RX:       ev_of = rx;
        `PLED_SEL_COL:      ev_of = col;
        `PLED_SEL_ACT:      ev_of = tx | rx;
        `PLED_SEL_LINK_RX:  ev_of = rx;
        `PLED_SEL_LINK_ACT: ev_of = tx | rx;
        `PLED_SEL_DUP_COL:  ev_of = col;
        default:            ev_of = 1'b0;
      endcase
    end
  endfunction

  // stretch duration in ms from the duration field
  function [6:0] dur_of;
    input [1:0] freq;
    begin
      case (freq)
        `PLED_FREQ_30:  dur_of = `PLED_STRETCH_30_MS;
        `PLED_FREQ_60:  dur_of = `PLED_STRETCH_60_MS;
        `PLED_FREQ_100: dur_of = `PLED_STRETCH_100_MS;
        // reserved code: take the longest so nothing is cut short
        default:        dur_of = `PLED_STRETCH_100_MS;
      endcase
    end
  endfunction

  // displayed level for one indicator, before polarity
  function disp_of;
    input [3:0] sel;
    input       str_en;
    input       ev_raw;
    input       ev_str;
    input       link;
    input       spd;
    input       dup;
    input       fast;
    input       slow;
    reg         plain_ev;
    begin
      plain_ev = str_en ? ev_str : ev_raw;
      case (sel)
        `PLED_SEL_SPEED:    disp_of = spd;
        `PLED_SEL_TX,
        `PLED_SEL_RX,
        `PLED_SEL_COL:      disp_of = plain_ev;
        `PLED_SEL_LINK:     disp_of = link;
        `PLED_SEL_DUPLEX:   disp_of = dup;
        `PLED_SEL_ACT:      disp_of = plain_ev;
        `PLED_SEL_ON:       disp_of = 1'b1;
        `PLED_SEL_OFF:      disp_of = 1'b0;
        `PLED_SEL_FAST:     disp_of = fast;
        `PLED_SEL_SLOW:     disp_of = slow;
        // solid while link (or duplex for 1101) up, blink phase knocks it off during events
        `PLED_SEL_LINK_RX,
        `PLED_SEL_LINK_ACT: disp_of = link & ~(ev_str & fast);
        `PLED_SEL_DUP_COL:  disp_of = dup & ~(ev_str & fast);
        default:            disp_of = 1'b0;
      endcase
    end
  endfunction

  reg  [15:0] cfg_r;
  reg  [17:0] div_r;
  reg         ms_tick_r;
  reg  [8:0]  fast_cnt_r;
  reg  [8:0]  slow_cnt_r;
  reg         fast_ph_r;
  reg         slow_ph_r;
  wire [5:0]  st_raw;
  wire [5:0]  st_s;
  wire        link_s;
  wire        spd_s;
  wire        dup_s;
  wire        tx_s;
  wire        rx_s;
  wire        col_s;
  wire        str_en;
  wire        pol;
  wire [6:0]  dur_ms;
  wire [2:0]  disp;
  wire        cfg_hit;

  // last divider count, sized once so the compare below stays 18 bits wide
  localparam [17:0] MS_LAST = MS_TICK_CYC - 1;

  assign cfg_hit = (REG_ADDR == `PLED_CFG_ADDR);
  assign str_en  = cfg_r[`PLED_STR_EN_BIT];
  assign pol     = cfg_r[`PLED_POL_BIT];
  assign dur_ms  = dur_of(cfg_r[`PLED_FREQ_MSB:`PLED_FREQ_LSB]);

  // configuration register; writes to other addresses are not ours
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST)
      cfg_r <= `PLED_CFG_RESET;
    else if (REG_WR && cfg_hit)
      cfg_r <= REG_WDATA;
  end

  // read answer one cycle after the strobe; other addresses read zero
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      REG_RDATA  <= 16'h0000;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD)
        REG_RDATA <= cfg_hit ? cfg_r : 16'h0000;
    end
  end

  // millisecond enable; every slower rate hangs off this one tick
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      div_r     <= 18'h00000;
      ms_tick_r <= 1'b0;
    end else if (div_r == MS_LAST) begin
      div_r     <= 18'h00000;
      ms_tick_r <= 1'b1;
    end else begin
      div_r     <= div_r + 18'h00001;
      ms_tick_r <= 1'b0;
    end
  end

  // blink phases: fixed half periods, fast well below slow
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      fast_cnt_r <= 9'h000;
      slow_cnt_r <= 9'h000;
      fast_ph_r  <= 1'b0;
      slow_ph_r  <= 1'b0;
    end else if (ms_tick_r) begin
      if (fast_cnt_r == `PLED_FAST_HALF_MS - 9'h001) begin
        fast_cnt_r <= 9'h000;
        fast_ph_r  <= ~fast_ph_r;
      end else begin
        fast_cnt_r <= fast_cnt_r + 9'h001;
      end
      if (slow_cnt_r == `PLED_SLOW_HALF_MS - 9'h001) begin
        slow_cnt_r <= 9'h000;
        slow_ph_r  <= ~slow_ph_r;
      end else begin
        slow_cnt_r <= slow_cnt_r + 9'h001;
      end
    end
  end

  // status from port logic on other clocks; short glitches are filtered
  assign st_raw = {COLLISION, RX_ACT, TX_ACT, FULL_DUPLEX, SPEED_100, LINK_UP};
  genvar s;
  generate
    for (s = 0; s < 6; s = s + 1) begin : g_sync
      pled_sync u_sync (
        .clk (CLOCK),
        .rst (SYS_RST),
        .d   (st_raw[s]),
        .q   (st_s[s])
      );
    end
  endgenerate
  assign link_s = st_s[0];
  assign spd_s  = st_s[1];
  assign dup_s  = st_s[2];
  assign tx_s   = st_s[3];
  assign rx_s   = st_s[4];
  assign col_s  = st_s[5];

  // one select field, stretcher and output pair per indicator
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_ind
      wire [3:0] sel;
      wire       ev_raw;
      wire       ev_str;
      // indicator one at 15:12, two at 11:8, three at 7:4
      assign sel    = cfg_r[`PLED_SEL1_MSB - 4*i -: 4];
      assign ev_raw = ev_of(sel, tx_s, rx_s, col_s);
      pled_stretch u_str (
        .clk     (CLOCK),
        .rst     (SYS_RST),
        .ev      (ev_raw),
        .ms_tick (ms_tick_r),
        .dur_ms  (dur_ms),
        .active  (ev_str)
      );
      assign disp[i] = disp_of(sel, str_en, ev_raw, ev_str, link_s, spd_s,
                               dup_s, fast_ph_r, slow_ph_r);
    end
  endgenerate

  // registered outputs; serial copy follows the polarity bit
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      IND_ON  <= 3'h0;
      IND_SER <= `PLED_SER_RESET;
    end else begin
      IND_ON  <= disp;
      IND_SER <= pol ? disp : ~disp;
    end
  end

endmodule // pled_top

/* File: pkg/pled_regs.vh */
/*
  Constants for the per-port indicator control block: register address,
  field positions, reset value, select codes and timing figures.
  Assumes a 250 MHz system clock and a 5-bit management register address.
*/
`ifndef PLED_REGS_VH
`define PLED_REGS_VH

// register map
`define PLED_CFG_ADDR      5'h14
`define PLED_CFG_RESET     16'h0422
`define PLED_SEL1_MSB      15
`define PLED_FREQ_MSB      3
`define PLED_FREQ_LSB      2
`define PLED_STR_EN_BIT    1
`define PLED_POL_BIT       0

// indicator select codes
`define PLED_SEL_SPEED     4'h0
`define PLED_SEL_TX        4'h1
`define PLED_SEL_RX        4'h2
`define PLED_SEL_COL       4'h3
`define PLED_SEL_LINK      4'h4
`define PLED_SEL_DUPLEX    4'h5
`define PLED_SEL_ACT       4'h7
`define PLED_SEL_ON        4'h8
`define PLED_SEL_OFF       4'h9
`define PLED_SEL_FAST      4'hA
`define PLED_SEL_SLOW      4'hB
`define PLED_SEL_LINK_RX   4'hC
`define PLED_SEL_DUP_COL   4'hD
`define PLED_SEL_LINK_ACT  4'hE

// stretch duration codes
`define PLED_FREQ_30       2'h0
`define PLED_FREQ_60       2'h1
`define PLED_FREQ_100      2'h2

// timing: clock rate, times in ms, cycles derived from them
`define PLED_CLK_KHZ       250000
`define PLED_MS_TICK_CYC   (`PLED_CLK_KHZ * 1)
`define PLED_STRETCH_30_MS 7'h1E
`define PLED_STRETCH_60_MS 7'h3C
`define PLED_STRETCH_100_MS 7'h64
`define PLED_FAST_HALF_MS  9'h032
`define PLED_SLOW_HALF_MS  9'h0FA

// serial outputs at reset: polarity bit is 0, so off means high
`define PLED_SER_RESET     3'h7

`endif

/* File: verification/pled_checker.sv */
/*
  Checker for the indicator block: register bus answers and indicators.
  Assumes it is bound to pled_top and sees only that module's ports.
*/
`timescale 1ns/100ps
`include "pled_regs.vh"
module pled_checker #(
  parameter MS_TICK_CYC = 8
) (
  input wire        CLOCK,
  input wire        SYS_RST,
  input wire [4:0]  REG_ADDR,
  input wire        REG_WR,
  input wire        REG_RD,
  input wire [15:0] REG_WDATA,
  input wire [15:0] REG_RDATA,
  input wire        REG_RVALID,
  input wire        LINK_UP,
  input wire [2:0]  IND_ON,
  input wire [2:0]  IND_SER
);
  reg [15:0] cfg_r;
  reg [1:0]  age_r;
  reg [2:0]  lnk_age_r;
  reg        lnk_r;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // shadow config; age gives outputs time to follow a write
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cfg_r <= `PLED_CFG_RESET;
      age_r <= 2'h3;
      lnk_age_r <= 3'h0;
      lnk_r <= 1'b0;
    end else begin
      if (REG_WR && REG_ADDR == `PLED_CFG_ADDR) cfg_r <= REG_WDATA;
      age_r <= (REG_WR && REG_ADDR == `PLED_CFG_ADDR) ? 2'h0 :
               (age_r == 2'h3 ? 2'h3 : age_r + 2'h1);
      lnk_age_r <= (LINK_UP != lnk_r) ? 3'h0 : (lnk_age_r == 3'h7 ? 3'h7 : lnk_age_r + 3'h1);
      lnk_r <= LINK_UP;
    end
  end
  a_rd_answer: assert property (REG_RD |=> REG_RVALID)
    else $error("read got no answer");
  a_no_stray: assert property (!REG_RD |=> !REG_RVALID)
    else $error("answer without read");
  a_rd_data: assert property (REG_RD && REG_ADDR == `PLED_CFG_ADDR |=> REG_RDATA == $past(cfg_r))
    else $error("config read data wrong");
  a_unmapped_zero: assert property (REG_RD && REG_ADDR != `PLED_CFG_ADDR |=> REG_RDATA == 16'h0000)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved");
  a_ser_pol: assert property (age_r >= 2'h2 |-> IND_SER == (cfg_r[0] ? IND_ON : ~IND_ON))
    else $error("serial polarity wrong");
  a_force_on: assert property (age_r >= 2'h2 && cfg_r[15:12] == 4'h8 |-> IND_ON[0])
    else $error("forced on not lit");
  a_reserved_off: assert property (age_r >= 2'h2 && cfg_r[11:8] == 4'h6 |-> !IND_ON[1])
    else $error("reserved code lit");
  a_link_follow: assert property (age_r >= 2'h2 && cfg_r[7:4] == 4'h4 && lnk_age_r == 3'h7
    |-> IND_ON[2] == lnk_r)
    else $error("link display wrong");
endmodule // pled_checker
bind pled_top pled_checker #(.MS_TICK_CYC(MS_TICK_CYC)) chk_u (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
  .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .LINK_UP(LINK_UP), .IND_ON(IND_ON),
  .IND_SER(IND_SER));

/* File: verification/pled_led_model.sv */
/*
  Model of the indicator lamps: what a viewer sees on each output.
  Assumes the polarity setting is handed in by whoever programs it.
*/
`timescale 1ns/100ps
module pled_led_model (
  input  wire [2:0] ind_on,
  input  wire [2:0] ind_ser,
  input  wire       pol,
  output wire [2:0] lit,
  output wire [2:0] ser_lit
);
  // discrete lamps are active high; serial lamps follow polarity
  assign lit     = ind_on;
  assign ser_lit = pol ? ind_ser : ~ind_ser;
endmodule // pled_led_model

/* File: verification/tb_pled_top.sv */
/*
  Testbench for the indicator block: register access and indicator modes.
  Assumes a small MS_TICK_CYC so one millisecond is eight cycles.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked = samples_checked + 1; \
  if ((g) !== (e)) begin bad_count = bad_count + 1; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_pled_top;
  reg         CLOCK = 1'b0;
  reg         SYS_RST = 1'b1;
  reg  [4:0]  REG_ADDR = 5'h00;
  reg         REG_WR = 1'b0;
  reg         REG_RD = 1'b0;
  reg  [15:0] REG_WDATA = 16'h0000;
  reg  [5:0]  st = 6'h00; // link, speed, duplex, tx, rx, collision
  reg         pol = 1'b0;
  reg  [2:0]  seen;
  wire [15:0] REG_RDATA;
  wire        REG_RVALID;
  wire [2:0]  IND_ON;
  wire [2:0]  IND_SER;
  wire [2:0]  lit;
  wire [2:0]  ser_lit;
  integer     bad_count = 0;
  integer     samples_checked = 0;
  integer     i;
  integer     j;
  integer     d;
  integer     n1;
  integer     n2;
  pled_top #(.MS_TICK_CYC(8)) dut_u (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .LINK_UP(st[5]), .SPEED_100(st[4]), .FULL_DUPLEX(st[3]),
    .TX_ACT(st[2]), .RX_ACT(st[1]), .COLLISION(st[0]), .IND_ON(IND_ON), .IND_SER(IND_SER));
  pled_led_model led_u (.ind_on(IND_ON), .ind_ser(IND_SER), .pol(pol), .lit(lit),
    .ser_lit(ser_lit));
  // 250 MHz
  always #2 CLOCK = ~CLOCK;
  task cyc(input integer n); begin
    repeat (n) @(posedge CLOCK);
    #1;
  end endtask
  task wr(input [4:0] a, input [15:0] v); begin
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_WDATA <= v;
    REG_WR <= 1'b1;
    @(posedge CLOCK);
    REG_WR <= 1'b0;
    if (a == 5'h14) pol <= v[0];
  end endtask
  task rd(input [4:0] a, input [15:0] e); begin
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLOCK);
    REG_RD <= 1'b0;
    #1;
    `CHK("rvalid", 1'b1, REG_RVALID)
    `CHK("rdata", e, REG_RDATA)
  end endtask
  task set_st(input [5:0] v); begin
    @(posedge CLOCK);
    st <= v;
  end endtask
  task chk_ind(input [2:0] e); begin
    `CHK("ind", e, lit)
    `CHK("ser", lit, ser_lit)
  end endtask
  task end_sim; begin
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  end endtask
  // bound on the whole run in case the design never settles
  initial begin
    cyc(30000);
    bad_count = bad_count + 1;
    end_sim;
  end
  // main sequence
  initial begin
    repeat (2) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    rd(5'h14, 16'h0422);
    wr(5'h13, 16'hFFFF);
    rd(5'h13, 16'h0000);
    rd(5'h14, 16'h0422);
    wr(5'h14, 16'h0452);
    set_st(6'h30);
    cyc(8);
    chk_ind(3'h3);
    set_st(6'h08);
    cyc(8);
    chk_ind(3'h4);
    wr(5'h14, 16'h8961);
    cyc(4);
    chk_ind(3'h1);
    rd(5'h14, 16'h8961);
    wr(5'h14, 16'hAB02);
    cyc(4);
    seen = lit;
    n1 = 0;
    n2 = 0;
    for (j = 0; j < 4000; j = j + 1) begin
      cyc(1);
      if (lit[0] !== seen[0]) n1 = n1 + 1;
      if (lit[1] !== seen[1]) n2 = n2 + 1;
      seen = lit;
    end
    `CHK("fast blink", 1'b1, (n1 >= 9 && n1 <= 11))
    `CHK("slow blink", 1'b1, (n2 >= 1 && n2 <= 2))
    // each stretch length, with a second event restarting the hold
    for (i = 0; i < 3; i = i + 1) begin
      d = (i == 0) ? 30 : ((i == 1) ? 60 : 100);
      wr(5'h14, {12'h123, i[1:0], 2'h2});
      set_st(6'h07);
      cyc(8);
      chk_ind(3'h7);
      set_st(6'h00);
      cyc(d * 4);
      set_st(6'h07);
      cyc(8);
      set_st(6'h00);
      cyc(d * 8 - 8);
      chk_ind(3'h7);
      cyc(24);
      chk_ind(3'h0);
    end
    wr(5'h14, 16'h7000);
    set_st(6'h02);
    cyc(8);
    chk_ind(3'h1);
    set_st(6'h00);
    cyc(10);
    chk_ind(3'h0);
    // combined displays with global stretch off
    wr(5'h14, 16'hCED8);
    set_st(6'h28);
    cyc(8);
    chk_ind(3'h7);
    set_st(6'h2B);
    cyc(8);
    set_st(6'h28);
    seen = 3'h7;
    for (j = 0; j < 800; j = j + 1) begin
      cyc(1);
      seen = seen & lit;
    end
    `CHK("blink seen", 3'h0, seen)
    cyc(200);
    chk_ind(3'h7);
    set_st(6'h00);
    cyc(8);
    chk_ind(3'h0);
    end_sim;
  end
endmodule // tb_pled_top
